// ### pkg/fsp_pkg.sv
// Purpose: constants shared by the FIFO serial port design
// Assumes: one 10 MHz clock, byte addressed Avalon-MM register window
// Notes: register words sit at aligned byte offsets, unused bits read zero

package fsp_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int DATA_W = 8;
	localparam int DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int STAT_W = 8;
	localparam int CTRL_W = 10;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_BAUD = 5'h04;
	localparam logic [4:0] OFF_TXDATA = 5'h08;
	localparam logic [4:0] OFF_RXDATA = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_MASK = 5'h14;
	localparam logic [4:0] OFF_PORT = 5'h18;
	localparam logic [4:0] OFF_ERRCNT = 5'h1C;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int C_TX_EN = 0;
	localparam int C_RX_EN = 1;
	localparam int C_SYNC = 2;
	localparam int C_EXT_CLK = 3;
	localparam int C_EIGHT = 4;
	localparam int C_TWO_STOP = 5;
	localparam int C_PAR_EN = 6;
	localparam int C_PAR_ODD = 7;
	localparam int C_DMA_SEL = 8;
	localparam int C_STANDBY = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h210;
	localparam logic [15:0] BAUD_RESET = 16'h0040;

	// ****************************************
	// Status and mask fields
	// ****************************************
	localparam int S_TXE = 0;
	localparam int S_BRK = 1;
	localparam int S_RXF = 2;
	localparam int S_RER = 3;
	localparam int S_PER = 4;
	localparam int S_FER = 5;
	localparam int S_ORE = 6;
	localparam int S_TOE = 7;

	// ****************************************
	// Timing counts and error count limit
	// ****************************************
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [7:0] ERRCNT_MAX = 8'hFF;
endpackage

// ### pkg/fsp_stream_if.sv
// Purpose: byte stream with valid and ready between port modules
// Assumes: transfer on a clock edge where valid and ready are both high
// Notes: no clock inside, the modules carry their own
`timescale 1ns/1ns
`default_nettype none

interface fsp_stream_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

`default_nettype wire

// ### design/fsp_fifo.sv
// Purpose: sixteen entry byte queue
// Assumes: push and pop may fall in the same cycle
// Notes: full refuses pushes through ready
`timescale 1ns/1ns
`default_nettype none

module fsp_fifo (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Streams
	fsp_stream_if.snk wr,
	fsp_stream_if.src rd,
	// Fill level
	output logic [fsp_pkg::CNT_W-1:0] count
);
	logic [7:0] mem [fsp_pkg::DEPTH];
	logic [fsp_pkg::PTR_W-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [fsp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic push, pop;

	assign wr.ready = (cnt_reg != fsp_pkg::CNT_W'(fsp_pkg::DEPTH));
	assign rd.valid = (cnt_reg != '0);
	assign rd.data = mem[rp_reg];
	assign count = cnt_reg;

	always_comb begin
		push = wr.valid & wr.ready;
		pop = rd.valid & rd.ready;
		wp_next = push ? wp_reg + 1'b1 : wp_reg;
		rp_next = pop ? rp_reg + 1'b1 : rp_reg;
		cnt_next = cnt_reg + {4'h0, push} - {4'h0, pop};
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp_reg] <= wr.data;
		end
	end
endmodule // fsp_fifo

`default_nettype wire

// ### design/fsp_tx_serial.sv
// Purpose: serialiser for asynchronous and synchronous frames
// Assumes: os_tick is sixteen per bit, sync_fall one per bit
// Notes: takes the next byte at the end of a frame for back to back output
`timescale 1ns/1ns
`default_nettype none

module fsp_tx_serial (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Byte source
	fsp_stream_if.snk s,
	// Configuration
	input wire logic enable,
	input wire logic sync_mode,
	input wire logic eight,
	input wire logic two_stop,
	input wire logic par_en,
	input wire logic par_odd,
	// Timing
	input wire logic os_tick,
	input wire logic sync_fall,
	// Line
	output logic txd
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fsp_tx_state_t;
	fsp_tx_state_t st_reg, st_next;
	logic [7:0] sh_reg, sh_next;
	logic [3:0] sub_reg, sub_next;
	logic [2:0] bit_reg, bit_next;
	logic par_reg, par_next, txd_reg, txd_next;
	logic step, fin, take;

	assign txd = txd_reg;

	always_comb begin
		st_next = st_reg;
		sh_next = sh_reg;
		bit_next = bit_reg;
		par_next = par_reg;
		txd_next = txd_reg;
		s.ready = 1'b0;
		step = sync_mode ? sync_fall : os_tick;
		sub_next = (os_tick && !sync_mode) ? sub_reg + 1'b1 : sub_reg;
		fin = sync_mode ? sync_fall : (os_tick && sub_reg == fsp_pkg::OS_LAST);
		take = 1'b0;
		unique case (st_reg)
			TX_IDLE: take = step;
			TX_START: if (fin) begin
				st_next = TX_DATA;
				txd_next = sh_reg[0];
				bit_next = '0;
			end
			TX_DATA: if (fin) begin
				sh_next = {1'b0, sh_reg[7:1]};
				if (bit_reg == (sync_mode || eight ? 3'h7 : 3'h6)) begin
					if (sync_mode) begin
						take = 1'b1;
						st_next = TX_IDLE;
						txd_next = 1'b1;
					end else begin
						st_next = par_en ? TX_PAR : TX_STOP;
						txd_next = par_en ? par_reg : 1'b1;
						bit_next = '0;
					end
				end else begin
					txd_next = sh_reg[1];
					bit_next = bit_reg + 1'b1;
				end
			end
			TX_PAR: if (fin) begin
				st_next = TX_STOP;
				txd_next = 1'b1;
			end
			TX_STOP: if (fin) begin
				if (two_stop && bit_reg == '0) begin
					bit_next = 3'h1;
				end else begin
					take = 1'b1;
					st_next = TX_IDLE;
				end
			end
		endcase
		if (take && s.valid && enable) begin
			s.ready = 1'b1;
			sh_next = s.data;
			par_next = ^(eight ? s.data : {1'b0, s.data[6:0]}) ^ par_odd;
			sub_next = '0;
			bit_next = '0;
			// Async start bit low, sync goes straight to data bit 0; data LSB first
			st_next = sync_mode ? TX_DATA : TX_START;
			txd_next = sync_mode ? s.data[0] : 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_reg <= TX_IDLE;
			sh_reg <= '0;
			sub_reg <= '0;
			bit_reg <= '0;
			par_reg <= 1'b0;
			txd_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			sh_reg <= sh_next;
			sub_reg <= sub_next;
			bit_reg <= bit_next;
			par_reg <= par_next;
			txd_reg <= txd_next;
		end
	end
endmodule // fsp_tx_serial

`default_nettype wire

// ### design/fsp_top.sv
// Purpose: FIFO serial port with Avalon-MM registers
// Assumes: one clock; rxd and sck pins are asynchronous to it
// Notes: standby after reset, release through the control register
`timescale 1ns/1ns
`default_nettype none

module fsp_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Serial pins
	input wire logic rxd_pin,
	output logic txd_pin,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	// Requests
	output logic irq,
	output logic transmit_queue_empty_request
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fsp_rx_state_t;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a[4:2] == off[4:2]);
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [fsp_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [15:0] baud_reg, baud_next;
	logic [fsp_pkg::STAT_W-1:0] mask_reg, mask_next, stat_reg, stat_next, stat_set;
	logic [7:0] errcnt_reg, errcnt_next;
	logic irq_reg, irq_next, dma_reg, dma_next;
	logic req, capture, wr, rd, standby;
	logic rxd_s1_reg, rxd_s2_reg, sck_s1_reg, sck_s2_reg;
	logic [15:0] bcnt_reg, bcnt_next;
	logic sck_int_reg, sck_int_next, clk_prev_reg, clk_prev_next;
	logic int_tick, clk_lvl, os_tick, sync_rise, sync_fall, sync_m, ext;
	logic txe_prev_reg, rxf_prev_reg;
	fsp_rx_state_t rst_reg, rst_next;
	logic [3:0] rsub_reg, rsub_next, flen;
	logic [2:0] rbit_reg, rbit_next;
	logic [7:0] rsh_reg, rsh_next, low_reg, low_next;
	logic [9:0] to_reg, to_next;
	logic rpar_reg, rpar_next, arm_reg, arm_next, tod_reg, tod_next;
	logic per, fer, ore, brk, toe, rx_push;
	logic [fsp_pkg::CNT_W-1:0] tx_count, rx_count;

	fsp_stream_if tx_in();
	fsp_stream_if tx_out();
	fsp_stream_if rx_in();
	fsp_stream_if rx_out();

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign irq = irq_reg;
	assign transmit_queue_empty_request = dma_reg;
	assign sck_out = sck_int_reg;

	// ****************************************
	// Queues and transmitter
	// ****************************************
	fsp_fifo u_tx_fifo (.clk_sys(clk_sys), .reset(reset), .wr(tx_in), .rd(tx_out), .count(tx_count));
	fsp_fifo u_rx_fifo (.clk_sys(clk_sys), .reset(reset), .wr(rx_in), .rd(rx_out), .count(rx_count));

	fsp_tx_serial u_tx (
		.clk_sys(clk_sys),
		.reset(reset),
		.s(tx_out),
		.enable(ctrl_reg[fsp_pkg::C_TX_EN]),
		.sync_mode(sync_m),
		.eight(ctrl_reg[fsp_pkg::C_EIGHT]),
		.two_stop(ctrl_reg[fsp_pkg::C_TWO_STOP]),
		.par_en(ctrl_reg[fsp_pkg::C_PAR_EN]),
		.par_odd(ctrl_reg[fsp_pkg::C_PAR_ODD]),
		.os_tick(os_tick),
		.sync_fall(sync_fall),
		.txd(txd_pin)
	);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rxd_s1_reg <= 1'b1;
			rxd_s2_reg <= 1'b1;
			sck_s1_reg <= 1'b1;
			sck_s2_reg <= 1'b1;
		end else begin
			rxd_s1_reg <= rxd_pin;
			rxd_s2_reg <= rxd_s1_reg;
			sck_s1_reg <= sck_in;
			sck_s2_reg <= sck_s1_reg;
		end
	end

	// ****************************************
	// Bus slave and registers
	// ****************************************
	always_comb begin
		standby = ctrl_reg[fsp_pkg::C_STANDBY];
		req = avs_read | avs_write;
		// One wait cycle, then accept
		capture = req & wait_reg;
		wr = avs_write & ~wait_reg;
		rd = avs_read & ~wait_reg;
		wait_next = ~capture;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		baud_next = baud_reg;
		mask_next = mask_reg;
		if (capture && avs_read) begin
			rdata_next = '0;
			if (hit(avs_address, fsp_pkg::OFF_CTRL)) rdata_next[fsp_pkg::CTRL_W-1:0] = ctrl_reg;
			if (hit(avs_address, fsp_pkg::OFF_BAUD)) rdata_next[15:0] = baud_reg;
			if (hit(avs_address, fsp_pkg::OFF_TXDATA)) rdata_next[4:0] = tx_count;
			if (hit(avs_address, fsp_pkg::OFF_RXDATA)) rdata_next[8:0] = {~rx_out.valid, rx_out.data};
			if (hit(avs_address, fsp_pkg::OFF_STATUS)) rdata_next[7:0] = stat_reg;
			if (hit(avs_address, fsp_pkg::OFF_MASK)) rdata_next[7:0] = mask_reg;
			if (hit(avs_address, fsp_pkg::OFF_PORT)) rdata_next[20:0] = {rx_count, 2'h0, tx_count, 8'h0, rxd_s2_reg};
			if (hit(avs_address, fsp_pkg::OFF_ERRCNT)) rdata_next[7:0] = errcnt_reg;
		end
		// Standby only lets the control word and the error count clear through
		if (wr && hit(avs_address, fsp_pkg::OFF_CTRL)) ctrl_next = avs_writedata[fsp_pkg::CTRL_W-1:0];
		if (wr && !standby && hit(avs_address, fsp_pkg::OFF_BAUD)) baud_next = avs_writedata[15:0];
		if (wr && !standby && hit(avs_address, fsp_pkg::OFF_MASK)) mask_next = avs_writedata[7:0];
		tx_in.valid = wr && !standby && hit(avs_address, fsp_pkg::OFF_TXDATA);
		tx_in.data = avs_writedata[7:0];
		rx_out.ready = rd && hit(avs_address, fsp_pkg::OFF_RXDATA);
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wait_reg <= 1'b1;
			rdata_reg <= '0;
			ctrl_reg <= fsp_pkg::CTRL_RESET;
			baud_reg <= fsp_pkg::BAUD_RESET;
			mask_reg <= '0;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			baud_reg <= baud_next;
			mask_reg <= mask_next;
		end
	end

	// ****************************************
	// Bit timing
	// ****************************************
	always_comb begin
		sync_m = ctrl_reg[fsp_pkg::C_SYNC];
		ext = ctrl_reg[fsp_pkg::C_EXT_CLK];
		int_tick = ~standby & (bcnt_reg == '0);
		bcnt_next = standby ? '0 : (int_tick ? baud_reg : bcnt_reg - 1'b1);
		sck_int_next = (sync_m && !ext && int_tick) ? ~sck_int_reg : sck_int_reg;
		clk_lvl = ext ? sck_s2_reg : sck_int_reg;
		clk_prev_next = clk_lvl;
		sync_rise = ~standby & sync_m & clk_lvl & ~clk_prev_reg;
		sync_fall = ~standby & sync_m & ~clk_lvl & clk_prev_reg;
		os_tick = ~standby & ~sync_m & (ext ? clk_lvl & ~clk_prev_reg : int_tick);
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bcnt_reg <= '0;
			sck_int_reg <= 1'b1;
			clk_prev_reg <= 1'b1;
			sck_oe <= 1'b0;
		end else begin
			bcnt_reg <= bcnt_next;
			sck_int_reg <= sck_int_next;
			clk_prev_reg <= clk_prev_next;
			sck_oe <= sync_m & ~ext & ~standby;
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	always_comb begin
		rst_next = rst_reg;
		rsub_next = os_tick ? rsub_reg + 1'b1 : rsub_reg;
		rbit_next = rbit_reg;
		rsh_next = rsh_reg;
		rpar_next = rpar_reg;
		arm_next = arm_reg;
		low_next = low_reg;
		to_next = to_reg;
		tod_next = tod_reg;
		{per, fer, ore, brk, toe, rx_push} = '0;
		flen = 4'h2 + {3'h0, ctrl_reg[fsp_pkg::C_EIGHT]} + 4'h6 + {3'h0, ctrl_reg[fsp_pkg::C_PAR_EN]}
			+ {3'h0, ctrl_reg[fsp_pkg::C_TWO_STOP]};
		rx_in.data = (sync_m || ctrl_reg[fsp_pkg::C_EIGHT]) ? rsh_reg : {1'b0, rsh_reg[7:1]};
		// Clocked mode, eight bits per byte
		if (sync_m) begin
			rst_next = RX_IDLE;
			if (sync_rise && ctrl_reg[fsp_pkg::C_RX_EN]) begin
				rsh_next = {rxd_s2_reg, rsh_reg[7:1]};
				rbit_next = rbit_reg + 1'b1;
				rx_push = (rbit_reg == 3'h7);
			end
		end else if (os_tick) begin
			unique case (rst_reg)
				RX_IDLE: begin
					rsub_next = '0;
					if (!rxd_s2_reg && ctrl_reg[fsp_pkg::C_RX_EN]) rst_next = RX_START;
				end
				RX_START: if (rsub_reg == fsp_pkg::OS_MID) begin
					rst_next = rxd_s2_reg ? RX_IDLE : RX_DATA;
					rsub_next = '0;
					rbit_next = '0;
					rpar_next = ctrl_reg[fsp_pkg::C_PAR_ODD];
				end
				RX_DATA: if (rsub_reg == fsp_pkg::OS_LAST) begin
					rsh_next = {rxd_s2_reg, rsh_reg[7:1]};
					rpar_next = rpar_reg ^ rxd_s2_reg;
					rbit_next = rbit_reg + 1'b1;
					if (rbit_reg == (ctrl_reg[fsp_pkg::C_EIGHT] ? 3'h7 : 3'h6))
						rst_next = ctrl_reg[fsp_pkg::C_PAR_EN] ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rsub_reg == fsp_pkg::OS_LAST) begin
					per = rpar_reg ^ rxd_s2_reg;
					rst_next = RX_STOP;
				end
				RX_STOP: if (rsub_reg == fsp_pkg::OS_LAST) begin
					fer = ~rxd_s2_reg;
					rx_push = 1'b1;
					rst_next = RX_IDLE;
				end
			endcase
		end
		rx_in.valid = rx_push & rx_in.ready;
		ore = rx_push & ~rx_in.ready;
		// Framing error then a frame time low
		// A held low line repeats framing errors, so only the first starts the count
		if (fer && !arm_reg) begin
			arm_next = 1'b1;
			low_next = '0;
		end else if (arm_reg && os_tick) begin
			low_next = low_reg + 1'b1;
			if (rxd_s2_reg) begin
				arm_next = 1'b0;
			end else if (low_reg == {flen, 4'h0} - 1'b1) begin
				brk = 1'b1;
				arm_next = 1'b0;
			end
		end
		// Four idle character times with data waiting
		if (sync_m || !rx_out.valid || rx_push || rst_reg != RX_IDLE) begin
			to_next = '0;
			tod_next = 1'b0;
		end else if (os_tick && !tod_reg) begin
			to_next = to_reg + 1'b1;
			if (to_reg == {flen, 6'h00} - 1'b1) begin
				toe = 1'b1;
				tod_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rst_reg <= RX_IDLE;
			rsub_reg <= '0;
			rbit_reg <= '0;
			rsh_reg <= '0;
			rpar_reg <= 1'b0;
			arm_reg <= 1'b0;
			low_reg <= '0;
			to_reg <= '0;
			tod_reg <= 1'b0;
		end else begin
			rst_reg <= rst_next;
			rsub_reg <= rsub_next;
			rbit_reg <= rbit_next;
			rsh_reg <= rsh_next;
			rpar_reg <= rpar_next;
			arm_reg <= arm_next;
			low_reg <= low_next;
			to_reg <= to_next;
			tod_reg <= tod_next;
		end
	end

	// ****************************************
	// Status, errors and requests
	// ****************************************
	always_comb begin
		stat_set = '0;
		stat_set[fsp_pkg::S_TXE] = ~tx_out.valid & txe_prev_reg == 1'b0;
		stat_set[fsp_pkg::S_BRK] = brk;
		stat_set[fsp_pkg::S_RXF] = ~rx_in.ready & ~rxf_prev_reg;
		stat_set[fsp_pkg::S_RER] = per | fer | ore | toe;
		stat_set[fsp_pkg::S_PER] = per;
		stat_set[fsp_pkg::S_FER] = fer;
		stat_set[fsp_pkg::S_ORE] = ore;
		stat_set[fsp_pkg::S_TOE] = toe;
		// Set wins over the read clear
		stat_next = stat_reg;
		if (rd && hit(avs_address, fsp_pkg::OFF_STATUS)) stat_next = stat_reg & ~rdata_reg[7:0];
		stat_next = stat_next | stat_set;
		errcnt_next = errcnt_reg;
		if (wr && hit(avs_address, fsp_pkg::OFF_ERRCNT)) errcnt_next = '0;
		if ((per | fer | ore) && errcnt_next != fsp_pkg::ERRCNT_MAX) errcnt_next = errcnt_next + 1'b1;
		// Empty request withheld from the interrupt line when DMA is selected
		irq_next = |(stat_next & mask_reg
			& ~(fsp_pkg::STAT_W'(ctrl_reg[fsp_pkg::C_DMA_SEL]) << fsp_pkg::S_TXE));
		// Level request, one byte per cycle steal
		dma_next = ctrl_reg[fsp_pkg::C_DMA_SEL] & ctrl_reg[fsp_pkg::C_TX_EN] & ~standby
			& tx_in.ready & ~tx_in.valid & ~tx_out.valid;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			stat_reg <= '0;
			errcnt_reg <= '0;
			irq_reg <= 1'b0;
			dma_reg <= 1'b0;
			txe_prev_reg <= 1'b1;
			rxf_prev_reg <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			errcnt_reg <= errcnt_next;
			irq_reg <= irq_next;
			dma_reg <= dma_next;
			txe_prev_reg <= ~tx_out.valid;
			rxf_prev_reg <= ~rx_in.ready;
		end
	end
endmodule // fsp_top

`default_nettype wire

// ### sim/fsp_top_asserts.sv
// Purpose: bus and line checks for the serial port top
// Assumes: control and mask are shadowed from accepted writes
// Notes: aligned offsets only
`timescale 1ns/1ns
`default_nettype none

module fsp_top_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Pins and requests
	input wire logic rxd_pin,
	input wire logic txd_pin,
	input wire logic sck_in,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic irq,
	input wire logic transmit_queue_empty_request
);
	logic [9:0] ctrl_reg, ctrl_next;
	logic [7:0] mask_reg, mask_next;
	logic acc;
	assign acc = !avs_waitrequest && (avs_read || avs_write);
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		if (acc && avs_write && avs_address == fsp_pkg::OFF_CTRL) begin
			ctrl_next = avs_writedata[9:0];
		end
		// Mask writes ignored in standby
		if (acc && avs_write && avs_address == fsp_pkg::OFF_MASK && !ctrl_reg[9]) begin
			mask_next = avs_writedata[7:0];
		end
	end
	// Mask starts as all ones so nothing is claimed before software sets it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl_reg <= fsp_pkg::CTRL_RESET;
			mask_reg <= 8'hFF;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_req;
		$rose(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ctrl_rd;
		acc && avs_read && avs_address == fsp_pkg::OFF_CTRL;
	endsequence
	a_wait_one: assert property (s_req |=> !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_ctrl_read: assert property (s_ctrl_rd |-> avs_readdata == {22'h0, ctrl_reg})
		else $error("control readback wrong");
	a_standby_quiet: assert property (ctrl_reg[9] && $past(ctrl_reg[9]) |->
		txd_pin && !sck_oe && !transmit_queue_empty_request)
		else $error("activity in standby");
	a_dma_gate: assert property (!ctrl_reg[8] && !$past(ctrl_reg[8]) |->
		!transmit_queue_empty_request)
		else $error("transfer request without selection");
	a_irq_mask: assert property (mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !irq)
		else $error("irq with all sources masked");
	a_sck_async: assert property (!ctrl_reg[2] && !$past(ctrl_reg[2]) |-> !sck_oe)
		else $error("clock driven in async mode");
	a_start_bit: assert property (!ctrl_reg[2] && $fell(txd_pin) |-> (!txd_pin)[*8])
		else $error("start bit too short");
	a_bit_hold: assert property (!ctrl_reg[2] && $changed(txd_pin) |=> $stable(txd_pin)[*7])
		else $error("line bit too short");
endmodule // fsp_top_asserts

bind fsp_top fsp_top_asserts chk_u (.clk_sys(clk_sys), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
	.sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .irq(irq),
	.transmit_queue_empty_request(transmit_queue_empty_request));

`default_nettype wire

// ### sim/fsp_remote.sv
// Purpose: remote async serial device
// Assumes: 16 clocks per bit (divisor zero)
// Notes: line idles high
`timescale 1ns/1ns
`default_nettype none

module fsp_remote (
	// Clock
	input wire logic clk_sys,
	// Line
	input wire logic txd_pin,
	output logic rxd_pin
);
	logic [7:0] got_byte;
	int got_cnt = 0;
	initial begin
		rxd_pin = 1'b1;
	end
	always begin
		@(negedge txd_pin);
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge clk_sys);
			got_byte[i] = txd_pin;
		end
		repeat (16) @(posedge clk_sys);
		if (txd_pin === 1'b1) got_cnt++;
	end
	// frame out, stop held low for breaks
	task automatic send(input logic [8:0] bits, input int n, input logic stop, input int hold);
		rxd_pin <= 1'b0;
		repeat (16) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			rxd_pin <= bits[i];
			repeat (16) @(posedge clk_sys);
		end
		rxd_pin <= stop;
		repeat (16 + hold) @(posedge clk_sys);
		rxd_pin <= 1'b1;
		@(posedge clk_sys);
	endtask
endmodule // fsp_remote

`default_nettype wire

// ### sim/test_fsp_top.sv
// Purpose: register level test of the serial port
// Assumes: divisor zero, so 16 clocks per bit
// Notes: external clock pin unused
`timescale 1ns/1ns
`default_nettype none

module test_fsp_top;
	logic clk_sys, reset, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic rxd_pin, txd_pin, sck_out, sck_oe, irq, dma_req;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	fsp_top dut_u (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd_pin(rxd_pin),
		.txd_pin(txd_pin), .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe), .irq(irq),
		.transmit_queue_empty_request(dma_req));
	fsp_remote rem_u (.clk_sys(clk_sys), .txd_pin(txd_pin), .rxd_pin(rxd_pin));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic finish_test();
		$display("Checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask
	task automatic wait_tx(input int n);
		for (int i = 0; i < 400 && rem_u.got_cnt < n; i++) @(posedge clk_sys);
		chk("tx count", 32'(n), 32'(rem_u.got_cnt));
	endtask
	task automatic wait_req();
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 400 && dma_req !== 1'b1; i++) @(posedge clk_sys);
		chk("dma req", 32'h1, {31'h0, dma_req});
	endtask
	initial begin
		reset = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rdc(fsp_pkg::OFF_CTRL, 32'h3FF, {22'h0, fsp_pkg::CTRL_RESET}, "ctrl reset");
		bus(1'b1, fsp_pkg::OFF_BAUD, 32'h0);
		rdc(fsp_pkg::OFF_BAUD, 32'hFFFF, {16'h0, fsp_pkg::BAUD_RESET}, "baud standby");
		bus(1'b1, fsp_pkg::OFF_CTRL, 32'h013);
		bus(1'b1, fsp_pkg::OFF_BAUD, 32'h0);
		bus(1'b1, fsp_pkg::OFF_MASK, 32'h0);
		bus(1'b1, fsp_pkg::OFF_TXDATA, 32'h5A);
		bus(1'b1, fsp_pkg::OFF_TXDATA, 32'hC3);
		wait_tx(1);
		chk("tx byte", 32'h5A, {24'h0, rem_u.got_byte});
		wait_tx(2);
		chk("tx byte", 32'hC3, {24'h0, rem_u.got_byte});
		for (int i = 0; i < 17; i++) rem_u.send({1'b0, 8'(i)}, 8, 1'b1, 0);
		rdc(fsp_pkg::OFF_STATUS, 32'h44, 32'h44, "rxf ore");
		rdc(fsp_pkg::OFF_ERRCNT, 32'hFF, 32'h1, "errcnt");
		bus(1'b1, fsp_pkg::OFF_ERRCNT, 32'h0);
		rdc(fsp_pkg::OFF_ERRCNT, 32'hFF, 32'h0, "errcnt clear");
		for (int i = 0; i < 16; i++) rdc(fsp_pkg::OFF_RXDATA, 32'h1FF, 32'(i), "rx byte");
		rdc(fsp_pkg::OFF_RXDATA, 32'h100, 32'h100, "rx empty");
		bus(1'b1, fsp_pkg::OFF_CTRL, 32'h053);
		rem_u.send(9'h001, 9, 1'b1, 0);
		rdc(fsp_pkg::OFF_STATUS, 32'h18, 32'h18, "parity");
		rdc(fsp_pkg::OFF_RXDATA, 32'h1FF, 32'h001, "parity byte");
		bus(1'b1, fsp_pkg::OFF_CTRL, 32'h0E3);
		rem_u.send(9'h0D5, 8, 1'b1, 16);
		rdc(fsp_pkg::OFF_STATUS, 32'h18, 32'h0, "odd parity");
		rdc(fsp_pkg::OFF_RXDATA, 32'h1FF, 32'h055, "seven bit byte");
		bus(1'b1, fsp_pkg::OFF_CTRL, 32'h013);
		bus(1'b1, fsp_pkg::OFF_MASK, 32'h0A);
		rdc(fsp_pkg::OFF_PORT, 32'h1, 32'h1, "rxd idle");
		fork
			rem_u.send(9'h000, 8, 1'b0, 200);
			begin
				repeat (250) @(posedge clk_sys);
				rdc(fsp_pkg::OFF_PORT, 32'h1, 32'h0, "rxd low");
			end
		join
		chk("irq set", 32'h1, {31'h0, irq});
		rdc(fsp_pkg::OFF_STATUS, 32'h2A, 32'h2A, "brk fer rer");
		repeat (2) @(posedge clk_sys);
		chk("irq clear", 32'h0, {31'h0, irq});
		bus(1'b1, fsp_pkg::OFF_MASK, 32'h01);
		bus(1'b1, fsp_pkg::OFF_CTRL, 32'h113);
		for (int i = 0; i < 2; i++) begin
			wait_req();
			chk("irq withheld", 32'h0, {31'h0, irq});
			bus(1'b1, fsp_pkg::OFF_TXDATA, 32'(8'hE0 + i));
		end
		wait_tx(4);
		chk("last dma byte", 32'hE1, {24'h0, rem_u.got_byte});
		bus(1'b1, fsp_pkg::OFF_CTRL, 32'h013);
		repeat (2) @(posedge clk_sys);
		chk("irq txe", 32'h1, {31'h0, irq});
		repeat (700) @(posedge clk_sys);
		rdc(fsp_pkg::OFF_STATUS, 32'h88, 32'h88, "timeout");
		finish_test();
	end
endmodule // test_fsp_top

`default_nettype wire
